//--- logic/dpr_pkg.sv
/*
 * dpr_pkg: shared constants, types and timing counts for the dual-port
 * memory host controller (apb register map, pin strobe bundle, fsm).
 * assumes a 25 MHz system clock; all times below are in nanoseconds.
 */
`default_nettype none
package dpr_pkg;
    // clock rate in MHz and conversion of a least time to whole cycles
    localparam int CLK_MHZ = 25;
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // device timing, slowest grade
    localparam int T_ACCESS_NS   = 25; // address/select to data valid
    localparam int T_WPULSE_NS   = 20; // select or write pulse width
    localparam int T_BUSY_WH_NS  = 17; // write held after busy release
    localparam int T_FLAGOP_NS   = 12; // flag update pulse between cycles
    localparam int ACCESS_CYC    = ns2cyc(T_ACCESS_NS);
    localparam int WPULSE_CYC    = ns2cyc(T_WPULSE_NS);
    localparam int BUSY_WH_CYC   = ns2cyc(T_BUSY_WH_NS);
    localparam int FLAGOP_CYC    = ns2cyc(T_FLAGOP_NS);
    localparam int SETTLE_CYC    = 4;  // pin synchroniser latency + margin
    localparam int CNT_W         = 4;

    // register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ADDR     = 8'h04;
    localparam logic [7:0] REG_WDATA    = 8'h08;
    localparam logic [7:0] REG_RDATA    = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] REG_IRQ_MASK = 8'h18;

    // control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_CMD_LO = 1;
    localparam int CTRL_LO_EN = 4;
    localparam int CTRL_HI_EN = 5;
    // status register fields
    localparam int STAT_ACTIVE  = 0;
    localparam int STAT_GRANTED = 1;
    localparam int STAT_BUSY    = 2;
    // interrupt status / mask fields
    localparam int IRQ_W        = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_LOST     = 1;
    localparam int IRQ_STALL    = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    typedef enum logic [1:0] {
        CMD_READ     = 2'h0,
        CMD_WRITE    = 2'h1,
        CMD_FLAG_REQ = 2'h2,
        CMD_FLAG_REL = 2'h3
    } dpr_cmd_e;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_SETUP    = 7'h02,
        ST_STROBE   = 7'h04,
        ST_BUSYHOLD = 7'h08,
        ST_CAPTURE  = 7'h10,
        ST_END      = 7'h20,
        ST_GAP      = 7'h40
    } dpr_state_e;

    // strobes of one device port, all active low except readNotWrite
    typedef struct packed {
        logic portSelectN;
        logic readNotWrite;
        logic outEnN;
        logic highByteSelectN;
        logic lowByteSelectN;
        logic flagSpaceSelectN;
    } dpr_pinctl_s;

    localparam dpr_pinctl_s PINS_IDLE = 6'h3F;
endpackage
`default_nettype wire

//--- logic/dpr_pin_sync.sv
/*
 * dpr_pin_sync: three-stage synchroniser for pin inputs; the output
 * moves only once stages two and three agree.
 * assumes one clock domain and a freeze-all clock enable.
 */
`timescale 1ns/1ps
`default_nettype none
module dpr_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         clkEn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // stage one is read by stage two only
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else if (clkEn) begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // agreement filter rejects a value caught mid-transition
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dout <= RST_VAL;
        end else if (clkEn && (s2_r == s3_r)) begin
            dout <= s3_r;
        end
    end
endmodule // dpr_pin_sync
`default_nettype wire

//--- logic/dpr_host.sv
/*
 * dpr_host: controller for one port of an asynchronous dual-port static
 * memory; software issues reads, byte writes and flag-space requests
 * through apb registers, the fsm drives the port strobes.
 * assumes the memory pins are wired directly; busy is an input here.
 */
// Decided for this implementation: the APB slave port and the register addresses.
// Functional notes
// - keep read_not_write high throughout every read cycle.
// - address-only reads apply to the array, never to flag space.
// - read_not_write is high whenever the address changes.
// - memory byte access needs port select low and flag select high.
// - flag write then read keeps port select high, flag select used.
// - a flag request writes zero on data bit 0, port select high.
// - never drive data while the device drives its data pins.
`timescale 1ns/1ps
`default_nettype none
module dpr_host #(
    parameter int ADDR_W = 14,
    parameter int DATA_W = 16
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               clkEn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    output logic      [ADDR_W-1:0]  memAddr,
    output dpr_pkg::dpr_pinctl_s    pinCtl,
    output logic      [DATA_W-1:0]  memDataOut,
    output logic                    memDataOe,
    input  wire logic [DATA_W-1:0]  memDataIn,
    input  wire logic               busyInN
);
    localparam int HALF_W = DATA_W / 2;

    // byte lanes need an even width, registers hold at most 32 bits
    if ((DATA_W % 2) != 0 || DATA_W < 2 || DATA_W > 32 ||
        ADDR_W < 3 || ADDR_W > 32) begin : g_badParam
        $error("dpr_host: unsupported ADDR_W or DATA_W");
    end

    dpr_pkg::dpr_state_e      state_r;
    dpr_pkg::dpr_cmd_e        cmd_r;
    logic [dpr_pkg::CNT_W-1:0] cnt_r;
    logic                     phaseRd_r;
    logic                     hiEn_r;
    logic                     loEn_r;
    logic [ADDR_W-1:0]        addrReg_r;
    logic [DATA_W-1:0]        wdata_r;
    logic [DATA_W-1:0]        rdata_r;
    logic                     granted_r;
    logic [dpr_pkg::IRQ_W-1:0] irqStat_r;
    logic [dpr_pkg::IRQ_W-1:0] irqStat_nxt;
    logic [dpr_pkg::IRQ_W-1:0] irqMask_r;
    logic [dpr_pkg::IRQ_W-1:0] evt_r;
    logic [31:0]              prdata_r;
    logic [DATA_W-1:0]        dataSync;
    logic                     busySyncN;
    logic                     apbWr;
    logic                     apbRd;
    logic                     mapped;
    logic                     startReq;
    logic                     isWrite;
    logic                     isFlag;

    function automatic logic [DATA_W-1:0] fit32(input logic [31:0] v);
        return v[DATA_W-1:0];
    endfunction

    function automatic logic [dpr_pkg::CNT_W-1:0] cyc(input int n);
        return n[dpr_pkg::CNT_W-1:0];
    endfunction

    // pin inputs cross four flops before use
    dpr_pin_sync #(.W(DATA_W), .RST_VAL('0)) u_dataSync (
        .clk    (clk),
        .resetn (resetn),
        .clkEn  (clkEn),
        .din    (memDataIn),
        .dout   (dataSync)
    );

    dpr_pin_sync #(.W(1), .RST_VAL(1'b1)) u_busySync (
        .clk    (clk),
        .resetn (resetn),
        .clkEn  (clkEn),
        .din    (busyInN),
        .dout   (busySyncN)
    );

    // apb decode: zero wait states, unmapped offsets answer pslverr
    always_comb begin
        mapped = (paddr == dpr_pkg::REG_CTRL) ||
                 (paddr == dpr_pkg::REG_ADDR) ||
                 (paddr == dpr_pkg::REG_WDATA) ||
                 (paddr == dpr_pkg::REG_RDATA) ||
                 (paddr == dpr_pkg::REG_STATUS) ||
                 (paddr == dpr_pkg::REG_IRQ_STAT) ||
                 (paddr == dpr_pkg::REG_IRQ_MASK);
        pready  = psel && penable;
        pslverr = psel && penable && !mapped;
        apbWr   = clkEn && psel && penable && pwrite && mapped;
        apbRd   = clkEn && psel && penable && !pwrite && mapped;
        prdata  = prdata_r;
        startReq = apbWr && (paddr == dpr_pkg::REG_CTRL) &&
                   pwdata[dpr_pkg::CTRL_START] &&
                   (state_r == dpr_pkg::ST_IDLE);
    end

    // read data latched in the setup phase so prdata comes from a flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (clkEn && psel && !penable) begin
            unique case (paddr)
                dpr_pkg::REG_CTRL: prdata_r <= {26'h0, hiEn_r, loEn_r,
                                                1'b0, cmd_r, 1'b0};
                dpr_pkg::REG_ADDR: prdata_r <= 32'(addrReg_r);
                dpr_pkg::REG_WDATA: prdata_r <= 32'(wdata_r);
                dpr_pkg::REG_RDATA: prdata_r <= 32'(rdata_r);
                dpr_pkg::REG_STATUS: prdata_r <= {29'h0, !busySyncN,
                    granted_r, (state_r != dpr_pkg::ST_IDLE)};
                dpr_pkg::REG_IRQ_STAT: prdata_r <= 32'(irqStat_r);
                dpr_pkg::REG_IRQ_MASK: prdata_r <= 32'(irqMask_r);
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // software-written registers; a write to ctrl while active is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addrReg_r <= '0;
            wdata_r   <= '0;
            irqMask_r <= dpr_pkg::IRQ_MASK_RST;
        end else if (apbWr) begin
            if (paddr == dpr_pkg::REG_ADDR) begin
                addrReg_r <= pwdata[ADDR_W-1:0];
            end
            if (paddr == dpr_pkg::REG_WDATA) begin
                wdata_r <= fit32(pwdata);
            end
            if (paddr == dpr_pkg::REG_IRQ_MASK) begin
                irqMask_r <= pwdata[dpr_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky events; read clears, but a same-cycle event still sets
    always_comb begin
        irqStat_nxt = irqStat_r;
        if (apbRd && (paddr == dpr_pkg::REG_IRQ_STAT)) begin
            irqStat_nxt = '0;
        end
        irqStat_nxt = irqStat_nxt | evt_r;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqStat_r <= '0;
        end else if (clkEn) begin
            irqStat_r <= irqStat_nxt;
        end
    end

    assign irq = |(irqStat_r & irqMask_r);

    // direction of the current phase: a flag request writes, then reads
    always_comb begin
        isFlag  = cmd_r[1];
        isWrite = (cmd_r == dpr_pkg::CMD_WRITE) ||
                  (cmd_r == dpr_pkg::CMD_FLAG_REL) ||
                  ((cmd_r == dpr_pkg::CMD_FLAG_REQ) && !phaseRd_r);
    end

    // port sequencer; address only moves in idle with the strobes high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r    <= dpr_pkg::ST_IDLE;
            cmd_r      <= dpr_pkg::CMD_READ;
            cnt_r      <= '0;
            phaseRd_r  <= 1'b0;
            hiEn_r     <= 1'b0;
            loEn_r     <= 1'b0;
            memAddr    <= '0;
            pinCtl     <= dpr_pkg::PINS_IDLE;
            memDataOut <= '0;
            memDataOe  <= 1'b0;
            rdata_r    <= '0;
            granted_r  <= 1'b0;
            evt_r      <= '0;
        end else if (clkEn) begin
            evt_r <= '0;
            unique case (state_r)
                dpr_pkg::ST_IDLE: begin
                    if (startReq) begin
                        cmd_r     <= dpr_pkg::dpr_cmd_e'(
                                     pwdata[dpr_pkg::CTRL_CMD_LO +: 2]);
                        hiEn_r    <= pwdata[dpr_pkg::CTRL_HI_EN];
                        loEn_r    <= pwdata[dpr_pkg::CTRL_LO_EN];
                        phaseRd_r <= 1'b0;
                        memAddr   <= addrReg_r;
                        state_r   <= dpr_pkg::ST_SETUP;
                    end
                end
                dpr_pkg::ST_SETUP: begin
                    // each access opens with a fresh select edge
                    if (isFlag) begin
                        pinCtl.flagSpaceSelectN <= 1'b0;
                        pinCtl.highByteSelectN  <= 1'b0;
                        pinCtl.lowByteSelectN   <= 1'b0;
                    end else begin
                        pinCtl.portSelectN      <= 1'b0;
                        pinCtl.highByteSelectN  <= !hiEn_r;
                        pinCtl.lowByteSelectN   <= !loEn_r;
                    end
                    if (isWrite) begin
                        // write low with the select keeps device drivers off
                        pinCtl.readNotWrite <= 1'b0;
                        memDataOe <= 1'b1;
                        if (isFlag) begin
                            // zero requests, one releases
                            memDataOut <= {{(DATA_W-1){1'b1}},
                                (cmd_r == dpr_pkg::CMD_FLAG_REL)};
                        end else begin
                            memDataOut <= wdata_r;
                        end
                        cnt_r <= cyc(dpr_pkg::WPULSE_CYC);
                    end else begin
                        pinCtl.outEnN <= 1'b0;
                        cnt_r <= cyc(dpr_pkg::ACCESS_CYC);
                    end
                    state_r <= dpr_pkg::ST_STROBE;
                end
                dpr_pkg::ST_STROBE: begin
                    if (!busySyncN) begin
                        // device holds the access off; keep strobes
                        evt_r[dpr_pkg::IRQ_STALL] <= 1'b1;
                        cnt_r   <= cyc(dpr_pkg::BUSY_WH_CYC);
                        state_r <= dpr_pkg::ST_BUSYHOLD;
                    end else if (cnt_r > cyc(1)) begin
                        cnt_r <= cnt_r - cyc(1);
                    end else if (isWrite) begin
                        state_r <= dpr_pkg::ST_END;
                    end else begin
                        cnt_r   <= cyc(dpr_pkg::SETTLE_CYC);
                        state_r <= dpr_pkg::ST_CAPTURE;
                    end
                end
                dpr_pkg::ST_BUSYHOLD: begin
                    // no bound on busy: a stuck busy stalls this port
                    if (!busySyncN) begin
                        cnt_r <= cyc(dpr_pkg::BUSY_WH_CYC);
                    end else if (cnt_r > cyc(1)) begin
                        cnt_r <= cnt_r - cyc(1);
                    end else if (isWrite) begin
                        state_r <= dpr_pkg::ST_END;
                    end else begin
                        cnt_r   <= cyc(dpr_pkg::SETTLE_CYC);
                        state_r <= dpr_pkg::ST_CAPTURE;
                    end
                end
                dpr_pkg::ST_CAPTURE: begin
                    if (cnt_r > cyc(1)) begin
                        cnt_r <= cnt_r - cyc(1);
                    end else begin
                        rdata_r <= dataSync;
                        if (isFlag) begin
                            // low on bit 0 means this port holds the flag
                            granted_r <= !dataSync[0];
                            evt_r[dpr_pkg::IRQ_LOST] <= dataSync[0];
                        end
                        state_r <= dpr_pkg::ST_END;
                    end
                end
                dpr_pkg::ST_END: begin
                    // selects rise first; write stays low so data holds
                    pinCtl.portSelectN      <= 1'b1;
                    pinCtl.flagSpaceSelectN <= 1'b1;
                    pinCtl.highByteSelectN  <= 1'b1;
                    pinCtl.lowByteSelectN   <= 1'b1;
                    pinCtl.outEnN           <= 1'b1;
                    if (cmd_r == dpr_pkg::CMD_FLAG_REL) begin
                        granted_r <= 1'b0;
                    end
                    cnt_r   <= cyc(dpr_pkg::FLAGOP_CYC);
                    state_r <= dpr_pkg::ST_GAP;
                end
                dpr_pkg::ST_GAP: begin
                    pinCtl.readNotWrite <= 1'b1;
                    memDataOe <= 1'b0;
                    if (cnt_r > cyc(1)) begin
                        cnt_r <= cnt_r - cyc(1);
                    end else if ((cmd_r == dpr_pkg::CMD_FLAG_REQ) &&
                                 !phaseRd_r) begin
                        phaseRd_r <= 1'b1;
                        state_r   <= dpr_pkg::ST_SETUP;
                    end else begin
                        evt_r[dpr_pkg::IRQ_DONE] <= 1'b1;
                        state_r <= dpr_pkg::ST_IDLE;
                    end
                end
                default: state_r <= dpr_pkg::ST_IDLE;
            endcase
        end
    end

    default clocking cbA @(posedge clk); endclocking
    default disable iff (!resetn || !clkEn);

    property p_read_rw;
        !pinCtl.outEnN |-> pinCtl.readNotWrite && !memDataOe;
    endproperty
    a_read_rw: assert property (p_read_rw)
        else $error("write low or data driven during read");

    property p_addr_rw;
        !$stable(memAddr) |-> pinCtl.readNotWrite &&
            $past(pinCtl.readNotWrite) && pinCtl.portSelectN;
    endproperty
    a_addr_rw: assert property (p_addr_rw)
        else $error("address moved with write low or port selected");

    property p_no_drive_read;
        memDataOe |-> !pinCtl.readNotWrite || $past(!pinCtl.readNotWrite);
    endproperty
    a_no_drive_read: assert property (p_no_drive_read)
        else $error("data driven outside a write");

    property p_flag_port_high;
        !pinCtl.flagSpaceSelectN |-> pinCtl.portSelectN;
    endproperty
    a_flag_port_high: assert property (p_flag_port_high)
        else $error("port select low during flag access");

    property p_byte_sel;
        !pinCtl.portSelectN |-> pinCtl.flagSpaceSelectN &&
            (pinCtl.highByteSelectN == !hiEn_r) &&
            (pinCtl.lowByteSelectN == !loEn_r);
    endproperty
    a_byte_sel: assert property (p_byte_sel)
        else $error("byte selects disagree with request");

    property p_select_with_write;
        $fell(pinCtl.portSelectN) && isWrite |-> !pinCtl.readNotWrite;
    endproperty
    a_select_with_write: assert property (p_select_with_write)
        else $error("write strobe late against select");

    property p_busy_stall;
        (state_r == dpr_pkg::ST_STROBE) && !busySyncN
            |=> (state_r == dpr_pkg::ST_BUSYHOLD) &&
                evt_r[dpr_pkg::IRQ_STALL];
    endproperty
    a_busy_stall: assert property (p_busy_stall)
        else $error("busy did not stall the access");

    property p_hold_stable;
        (state_r == dpr_pkg::ST_BUSYHOLD) |-> $stable(pinCtl) &&
            $stable(memDataOut);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("strobes moved while held off by busy");

    property p_grant;
        (state_r == dpr_pkg::ST_CAPTURE) && (cnt_r == cyc(1)) && isFlag
            |=> granted_r == !$past(dataSync[0]);
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant does not follow flag read");

    property p_flag_req_data;
        (state_r == dpr_pkg::ST_STROBE) && isFlag && isWrite
            |-> memDataOut[0] == (cmd_r == dpr_pkg::CMD_FLAG_REL);
    endproperty
    a_flag_req_data: assert property (p_flag_req_data)
        else $error("wrong flag request value");

    property p_write_overlap;
        (state_r == dpr_pkg::ST_GAP) |-> pinCtl.portSelectN &&
            pinCtl.flagSpaceSelectN && pinCtl.outEnN;
    endproperty
    a_write_overlap: assert property (p_write_overlap)
        else $error("select still low after access end");

    c_write: cover property (state_r == dpr_pkg::ST_END && isWrite &&
        !isFlag);
    c_read: cover property (state_r == dpr_pkg::ST_CAPTURE && !isFlag);
    c_grant: cover property ($rose(granted_r));
    c_stall: cover property (state_r == dpr_pkg::ST_BUSYHOLD);
endmodule // dpr_host
`default_nettype wire

//--- sim/dpr_dev_model.sv
/* dpr_dev_model: behavioural memory port with one flag in flag space.
   assumes host strobes from dpr_host; bench sets busy and other port. */
`timescale 1ns/1ps
`default_nettype none
module dpr_dev_model (
    input  wire logic                 clk,
    input  wire dpr_pkg::dpr_pinctl_s pins,
    input  wire logic [13:0]          addr,
    input  wire logic [15:0]          dIn,
    input  wire logic                 busyN,
    input  wire logic                 otherHeld,
    output logic      [15:0]          dOut,
    output logic                      oe
);
    logic [15:0] mem [0:255];
    logic        held = 1'b0; // flag released at start
    logic        sel;
    logic        fsel;
    assign sel = !pins.portSelectN && pins.flagSpaceSelectN;
    assign fsel = pins.portSelectN && !pins.flagSpaceSelectN;
    // write only in select/lane overlap, held off while busy
    always @(posedge clk) begin
        if ((sel || fsel) && !pins.readNotWrite && busyN &&
            !(pins.lowByteSelectN && pins.highByteSelectN)) begin
            if (fsel) held <= dIn[0] ? 1'b0 : !otherHeld;
            else begin
                if (!pins.lowByteSelectN) mem[addr[7:0]][7:0] <= dIn[7:0];
                if (!pins.highByteSelectN) mem[addr[7:0]][15:8] <= dIn[15:8];
            end
        end
    end
    // outputs stay off whenever write is low
    assign oe = (sel || fsel) && pins.readNotWrite && !pins.outEnN;
    assign dOut = fsel ? {15'h7FFF, !held} : mem[addr[7:0]];
endmodule // dpr_dev_model
`default_nettype wire

//--- sim/dpr_host_tb.sv
/* dpr_host_tb: apb-driven checks of dpr_host against the memory model.
   assumes zero-wait apb and the register map of dpr_pkg. */
`timescale 1ns/1ps
`default_nettype none
module dpr_host_tb;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic busyN = 1, other = 0, ce = 1, perr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, hostOe, devOe;
    logic [13:0] addr;
    logic [15:0] hostD, devD, bus, flt = 16'h0;
    dpr_pkg::dpr_pinctl_s pins;
    int errCount = 0, checked = 0;
    initial forever #20 clk = ~clk;
    // undriven bus shows a changing pattern, never the last value
    always @(posedge clk) flt <= ~flt;
    assign bus = devOe ? devD : hostOe ? hostD : flt;
    dpr_host DUT (.clk(clk), .resetn(resetn), .clkEn(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .memAddr(addr), .pinCtl(pins), .memDataOut(hostD),
        .memDataOe(hostOe), .memDataIn(bus), .busyInN(busyN));
    dpr_dev_model MEM (.clk(clk), .pins(pins), .addr(addr), .dIn(hostD),
        .busyN(busyN), .otherHeld(other), .dOut(devD), .oe(devOe));
    task automatic end_sim;
        $display("errors %0d checks %0d", errCount, checked);
        if (errCount == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin errCount++; end_sim; end
        rd = prdata; perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // poll until the port is idle; a start while active is dropped
    task automatic idle;
        int n;
        n = 0;
        do begin apb(0, dpr_pkg::REG_STATUS, 0); n++;
        end while (rd[0] !== 1'b0 && n < 100);
        if (rd[0] !== 1'b0) begin errCount++; end_sim; end
    endtask
    // start a command and wait for it to finish
    task automatic run(input logic [1:0] c, input logic lo, input logic hi);
        apb(1, dpr_pkg::REG_CTRL, {26'h0, hi, lo, 1'b0, c, 1'b1});
        idle;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    // host and device must never drive the data pins together
    always @(posedge clk) if (resetn && hostOe && devOe) chk(1, 0);
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        rdchk(dpr_pkg::REG_IRQ_MASK, 0);
        apb(1, dpr_pkg::REG_IRQ_MASK, 32'h7);
        rdchk(8'h1C, 0);
        chk({31'h0, perr}, 1);
        apb(1, dpr_pkg::REG_ADDR, 5);
        ce <= 0; // frozen: this write must not land
        apb(1, dpr_pkg::REG_ADDR, 32'h9);
        ce <= 1;
        rdchk(dpr_pkg::REG_ADDR, 5);
        apb(1, dpr_pkg::REG_WDATA, 32'hA55A);
        run(2'h1, 1, 1);
        chk({31'h0, irq}, 1);
        rdchk(dpr_pkg::REG_IRQ_STAT, 1);
        rdchk(dpr_pkg::REG_IRQ_STAT, 0);
        chk({31'h0, irq}, 0);
        apb(1, dpr_pkg::REG_WDATA, 32'h1234);
        run(2'h1, 1, 0);
        run(2'h0, 1, 1);
        rdchk(dpr_pkg::REG_RDATA, 32'hA534);
        // losing port sees busy; write must wait for its release
        busyN <= 0;
        apb(1, dpr_pkg::REG_WDATA, 32'h0F0F);
        apb(1, dpr_pkg::REG_CTRL, 32'h33);
        repeat (20) @(posedge clk);
        rdchk(dpr_pkg::REG_STATUS, 32'h5);
        busyN <= 1;
        idle;
        run(2'h0, 1, 1);
        rdchk(dpr_pkg::REG_RDATA, 32'h0F0F);
        rdchk(dpr_pkg::REG_IRQ_STAT, 32'h5);
        apb(1, dpr_pkg::REG_ADDR, 2);
        run(2'h2, 1, 1);
        rdchk(dpr_pkg::REG_STATUS, 32'h2);
        run(2'h3, 1, 1);
        rdchk(dpr_pkg::REG_STATUS, 0);
        other <= 1;
        run(2'h2, 1, 1);
        rdchk(dpr_pkg::REG_STATUS, 0);
        rdchk(dpr_pkg::REG_IRQ_STAT, 32'h3);
        end_sim;
    end
endmodule // dpr_host_tb
`default_nettype wire
